// ### filtered_pulse_counter_bank_test.sv
// Self-checking bench for the filtered pulse counter bank
`default_nettype none
module filtered_pulse_counter_bank_test
  import fpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 20;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic [NUM_DIN-1:0] DIN;
  logic [NUM_EXP-1:0] EXP_IN;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  fpc_counter_bank #(.MS_TICK_CYCLES(TICK)) fpc_counter_bank_inst (.CLOCK(CLOCK), .RSTN(RSTN), .DIN(DIN),
    .EXP_IN(EXP_IN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
  fpc_plant_model fpc_plant_model_inst (.CLOCK(CLOCK), .DIN(DIN), .EXP_IN(EXP_IN));

  always #20 CLOCK = ~CLOCK;

  // ------------------------------------------------------------
  // Bus and check helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string msg);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(negedge CLOCK);
    chk(RDATA, e, msg);
  endtask : rd_chk

  // Fresh configuration with all counters cleared
  task automatic setup(input logic [31:0] edges, input logic [31:0] src, input logic [31:0] lo,
                       input logic [31:0] hi);
    wr(OFS_EDGE, edges);
    wr(OFS_SRC_A, src);
    wr(OFS_SRC_B, 32'h0000_0000);
    wr(OFS_CLR_A, 32'h0000_0000);
    wr(OFS_LOW_MS, lo);
    wr(OFS_HIGH_MS, hi);
    wr(OFS_CLEAR_CMD, 32'h0000_ffff);
  endtask : setup

  task automatic settle();
    repeat (40) @(posedge CLOCK);
  endtask : settle

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd_chk(OFS_EDGE, 32'h0000_0000, "edge reset");
    rd_chk(OFS_COUNT_BASE, 32'h0000_0000, "count reset");
    rd_chk(8'hfc, 32'h0000_0000, "unmapped read");
    wr(OFS_SRC_A, 32'hffff_ffff);
    rd_chk(OFS_SRC_A, SEL_MASK, "select mask");
  endtask : t_reset

  task automatic t_edges();
    for (int e = 0; e < 4; e++) begin
      setup(32'(e), 32'h0000_0014, 32'h0, 32'h0);
      fpc_plant_model_inst.pulse(19, 6, 6, 3);
      settle();
      rd_chk(OFS_COUNT_BASE, 32'((e % 2) * 3 + (e / 2) * 3), "edge modes");
    end
  endtask : t_edges

  // Counter 1 on input 12, counter 2 on slow 13, counter 7 on fast 15, expansion 0
  task automatic t_route();
    setup(32'h0001_4014, 32'h000d_0c00, 32'h0, 32'h0);
    wr(OFS_SRC_B, 32'h0f00_0000);
    fpc_plant_model_inst.pulse(11, 60, 60, 2);
    fpc_plant_model_inst.pulse(12, 60, 60, 2);
    fpc_plant_model_inst.pulse(14, 3, 3, 4);
    fpc_plant_model_inst.pulse(20, 6, 6, 2);
    settle();
    rd_chk(OFS_COUNT_BASE + 8'h04, 32'h0000_0000, "invalid source");
    rd_chk(OFS_COUNT_BASE + 8'h08, 32'h0000_0002, "slow input");
    rd_chk(OFS_COUNT_BASE + 8'h1c, 32'h0000_0004, "fast short pulses");
    rd_chk(OFS_COUNT_BASE + 8'h20, 32'h0000_0002, "expansion counter");
  endtask : t_route

  task automatic t_filter();
    setup(32'h0000_0001, 32'h0000_0014, 32'h0, 32'h3);
    fpc_plant_model_inst.pulse(19, 20, 200, 2);
    settle();
    rd_chk(OFS_COUNT_BASE, 32'h0000_0000, "short highs");
    fpc_plant_model_inst.pulse(19, 200, 200, 1);
    settle();
    rd_chk(OFS_COUNT_BASE, 32'h0000_0001, "long high");
    setup(32'h0000_0001, 32'h0000_0014, 32'h3, 32'h0);
    fpc_plant_model_inst.pulse(19, 200, 20, 1);
    fpc_plant_model_inst.pulse(19, 200, 200, 2);
    settle();
    rd_chk(OFS_COUNT_BASE, 32'h0000_0002, "short low");
  endtask : t_filter

  task automatic t_clear();
    setup(32'h0000_0001, 32'h0000_0014, 32'h0, 32'h0);
    fpc_plant_model_inst.pulse(19, 6, 6, 3);
    settle();
    rd_chk(OFS_COUNT_BASE, 32'h0000_0003, "count before clear");
    wr(OFS_CLR_A, 32'h0000_0001);
    fpc_plant_model_inst.set_pin(0, 1'b1);
    fpc_plant_model_inst.pulse(19, 6, 6, 3);
    settle();
    rd_chk(OFS_COUNT_BASE, 32'h0000_0000, "held by clear input");
    fpc_plant_model_inst.set_pin(0, 1'b0);
    settle();
    fpc_plant_model_inst.pulse(19, 6, 6, 2);
    settle();
    rd_chk(OFS_COUNT_BASE, 32'h0000_0002, "count after clear");
  endtask : t_clear

  // ------------------------------------------------------------
  // Sequence, timeout and verdict
  // ------------------------------------------------------------
  task automatic end_sim();
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge CLOCK);
    RSTN <= 1'b1;
    t_reset();
    t_edges();
    t_route();
    t_filter();
    t_clear();
    end_sim();
  end
endmodule : filtered_pulse_counter_bank_test
`default_nettype wire

// ### fpc_counter_bank.sv
// Filtered pulse counter bank with register port
`default_nettype none

// Behaviour
// - Eight local counters, each fed by chosen input
// - Rising and falling enable bits per counter
// - No edge bits set means no counting
// - Low periods below minimum time are ignored
// - High periods below minimum time are ignored
// - Only inputs 13 to 20 may count
// - Inputs 15 to 20 take fast path
// - Clear input per local counter forces zero
// - Counts are raw, never scaled
// - Every counter readable in own slot
// - Two expansion modules, four counters each
module fpc_counter_bank
  import fpc_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [NUM_DIN-1:0] DIN,
  input wire logic [NUM_EXP-1:0] EXP_IN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA
);

  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  function automatic logic [SEL_W-1:0] sel_field(input logic [63:0] pair, input int ch);
    sel_field = pair[ch*SEL_STRIDE +: SEL_W];
  endfunction : sel_field

  function automatic logic pin_pick(input logic [NUM_DIN-1:0] v, input logic [SEL_W-1:0] n);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < NUM_DIN; k++) begin
      if (int'(n) == k + 1) begin
        hit = v[k];
      end
    end
    pin_pick = hit;
  endfunction : pin_pick

  function automatic logic src_ok(input logic [SEL_W-1:0] n);
    src_ok = (int'(n) >= FIRST_SRC) && (int'(n) <= LAST_SRC);
  endfunction : src_ok

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [NUM_DIN-1:0] din_s1_reg, din_s2_reg, din_s3_reg, din_stable_reg, din_slow_reg;
  logic [NUM_EXP-1:0] exp_s1_reg, exp_s2_reg, exp_s3_reg, exp_stable_reg;
  logic [NUM_DIN-1:0] din_qual;
  logic [15:0] ms_cnt_reg;
  logic [7:0] slow_cnt_reg;
  logic ms_tick, slow_tick;
  logic [31:0] edge_reg, src_a_reg, src_b_reg, clr_a_reg, clr_b_reg;
  logic [MS_W-1:0] low_ms_reg, high_ms_reg;
  logic [CNT_W-1:0] cnt_reg [NUM_CH];
  logic [MS_W-1:0] dur_reg [NUM_CH];
  logic [NUM_CH-1:0] filt_reg;
  logic [NUM_CH-1:0] raw_w, clr_w, valid_w, flip_w, rise_w, fall_w, inc_w;
  logic [NUM_CH-1:0] sw_clear;
  logic [31:0] rd_mux;
  logic [31:0] rdata_next;
  logic cnt_hit;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      din_s1_reg <= '0;
      din_s2_reg <= '0;
      din_s3_reg <= '0;
      exp_s1_reg <= '0;
      exp_s2_reg <= '0;
      exp_s3_reg <= '0;
    end else begin
      din_s1_reg <= DIN;
      din_s2_reg <= din_s1_reg;
      din_s3_reg <= din_s2_reg;
      exp_s1_reg <= EXP_IN;
      exp_s2_reg <= exp_s1_reg;
      exp_s3_reg <= exp_s2_reg;
    end
  end

  // Accept a level once two stages agree
  generate
    for (genvar k = 0; k < NUM_DIN; k++) begin : g_din
      always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          din_stable_reg[k] <= 1'b0;
        end else if (din_s2_reg[k] == din_s3_reg[k]) begin
          din_stable_reg[k] <= din_s3_reg[k];
        end
      end
      // Fast pins bypass the slow sampler
      if (k + 1 >= FIRST_FAST) begin : g_fast
        assign din_qual[k] = din_stable_reg[k];
      end else if (k + 1 >= FIRST_SRC) begin : g_slow
        assign din_qual[k] = din_slow_reg[k];
      end else begin : g_none
        assign din_qual[k] = 1'b0;
      end
    end
    for (genvar e = 0; e < NUM_EXP; e++) begin : g_exp
      always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          exp_stable_reg[e] <= 1'b0;
        end else if (exp_s2_reg[e] == exp_s3_reg[e]) begin
          exp_stable_reg[e] <= exp_s3_reg[e];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------
  assign ms_tick = (ms_cnt_reg == 16'(MS_TICK_CYCLES - 1));
  assign slow_tick = (slow_cnt_reg == 8'(SLOW_CYCLES - 1));

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ms_cnt_reg <= '0;
      slow_cnt_reg <= '0;
      din_slow_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
      slow_cnt_reg <= slow_tick ? 8'h00 : slow_cnt_reg + 8'h01;
      if (slow_tick) begin
        din_slow_reg <= din_stable_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  assign sw_clear = (WR && ADDR == OFS_CLEAR_CMD) ? WDATA[NUM_CH-1:0] : '0;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      edge_reg <= RST_EDGE;
      low_ms_reg <= RST_MS;
      high_ms_reg <= RST_MS;
      src_a_reg <= RST_SEL;
      src_b_reg <= RST_SEL;
      clr_a_reg <= RST_SEL;
      clr_b_reg <= RST_SEL;
    end else if (WR) begin
      if (ADDR == OFS_EDGE) edge_reg <= WDATA;
      if (ADDR == OFS_LOW_MS) low_ms_reg <= WDATA[MS_W-1:0];
      if (ADDR == OFS_HIGH_MS) high_ms_reg <= WDATA[MS_W-1:0];
      if (ADDR == OFS_SRC_A) src_a_reg <= WDATA & SEL_MASK;
      if (ADDR == OFS_SRC_B) src_b_reg <= WDATA & SEL_MASK;
      if (ADDR == OFS_CLR_A) clr_a_reg <= WDATA & SEL_MASK;
      if (ADDR == OFS_CLR_B) clr_b_reg <= WDATA & SEL_MASK;
    end
  end

  // ------------------------------------------------------------
  // Counter channels
  // ------------------------------------------------------------
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      logic [SEL_W-1:0] src_n, clr_n;
      logic [MS_W-1:0] min_t;
      logic differs;
      logic [MS_W-1:0] dur_next;
      logic [CNT_W-1:0] cnt_next;
      if (g < NUM_LOCAL) begin : g_local
        assign src_n = sel_field({src_b_reg, src_a_reg}, g);
        assign clr_n = sel_field({clr_b_reg, clr_a_reg}, g);
        assign valid_w[g] = src_ok(src_n);
        assign raw_w[g] = valid_w[g] & pin_pick(din_qual, src_n);
        assign clr_w[g] = pin_pick(din_stable_reg, clr_n) | sw_clear[g];
      end else begin : g_expch
        assign src_n = '0;
        assign clr_n = '0;
        assign valid_w[g] = 1'b1;
        assign raw_w[g] = exp_stable_reg[g-NUM_LOCAL];
        assign clr_w[g] = sw_clear[g];
      end
      // Minimum time for the level being entered
      assign min_t = raw_w[g] ? high_ms_reg : low_ms_reg;
      assign differs = raw_w[g] != filt_reg[g];
      assign flip_w[g] = differs && (dur_reg[g] >= min_t);
      assign dur_next = !differs ? '0 :
        (ms_tick && dur_reg[g] != '1) ? dur_reg[g] + 16'h0001 : dur_reg[g];
      assign rise_w[g] = flip_w[g] & raw_w[g];
      assign fall_w[g] = flip_w[g] & ~raw_w[g];
      assign inc_w[g] = valid_w[g] &
        ((rise_w[g] & edge_reg[2*g]) | (fall_w[g] & edge_reg[2*g+1]));
      // Clear wins, then plain binary wrap
      assign cnt_next = clr_w[g] ? '0 : inc_w[g] ? cnt_reg[g] + 32'h0000_0001 : cnt_reg[g];

      always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          filt_reg[g] <= 1'b0;
          dur_reg[g] <= '0;
          cnt_reg[g] <= '0;
        end else begin
          filt_reg[g] <= flip_w[g] ? raw_w[g] : filt_reg[g];
          dur_reg[g] <= dur_next;
          cnt_reg[g] <= cnt_next;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  assign cnt_hit = (ADDR >= OFS_COUNT_BASE) && (ADDR < OFS_COUNT_END) && (ADDR[1:0] == 2'b00);
  assign rd_mux =
    cnt_hit ? cnt_reg[ADDR[5:2]] :
    (ADDR == OFS_EDGE) ? edge_reg :
    (ADDR == OFS_LOW_MS) ? {16'h0000, low_ms_reg} :
    (ADDR == OFS_HIGH_MS) ? {16'h0000, high_ms_reg} :
    (ADDR == OFS_SRC_A) ? src_a_reg :
    (ADDR == OFS_SRC_B) ? src_b_reg :
    (ADDR == OFS_CLR_A) ? clr_a_reg :
    (ADDR == OFS_CLR_B) ? clr_b_reg :
    (ADDR == OFS_STATE) ? {16'h0000, filt_reg} :
    32'h0000_0000;
  assign rdata_next = RD ? rd_mux : 32'h0000_0000;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= '0;
    end else begin
      RDATA <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  no_edge_hold_a: assert property (
    (edge_reg[1:0] == 2'b00 && !clr_w[0]) |=> cnt_reg[0] == $past(cnt_reg[0]))
    else $error("Counter 0 moved with no edge enabled");

  rise_count_a: assert property (
    (rise_w[0] && edge_reg[0] && valid_w[0] && !clr_w[0]) |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h0000_0001)
    else $error("Rising edge not counted once");

  fall_count_a: assert property (
    (fall_w[0] && edge_reg[1] && valid_w[0] && !clr_w[0]) |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h0000_0001)
    else $error("Falling edge not counted once");

  low_filter_a: assert property (
    $fell(filt_reg[0]) |-> $past(dur_reg[0]) >= $past(low_ms_reg))
    else $error("Short low period passed the filter");

  high_filter_a: assert property (
    $rose(filt_reg[0]) |-> $past(dur_reg[0]) >= $past(high_ms_reg))
    else $error("Short high period passed the filter");

  bad_source_a: assert property (
    (!valid_w[0] && !clr_w[0]) |=> $stable(cnt_reg[0]))
    else $error("Counter 0 moved with an illegal source");

  fast_path_a: assert property (
    ($changed(DIN[NUM_DIN-1]) ##1 $stable(DIN[NUM_DIN-1]) [*3]) |=> din_qual[NUM_DIN-1] == $past(DIN[NUM_DIN-1]))
    else $error("Fast input not seen within four cycles");

  clear_zero_a: assert property (
    clr_w[0] |=> cnt_reg[0] == 32'h0000_0000)
    else $error("Clear did not zero counter 0");

  slot_read_a: assert property (
    (RD && ADDR == OFS_COUNT_BASE + 8'h04) |=> RDATA == $past(cnt_reg[1]))
    else $error("Slot 1 read returned wrong count");

  exp_count_a: assert property (
    (inc_w[NUM_LOCAL] && !clr_w[NUM_LOCAL]) |=> cnt_reg[NUM_LOCAL] == $past(cnt_reg[NUM_LOCAL]) + 32'h0000_0001)
    else $error("Expansion counter missed an edge");

  wrap_zero_a: assert property (
    (inc_w[0] && !clr_w[0] && cnt_reg[0] == 32'hffff_ffff) |=> cnt_reg[0] == 32'h0000_0000)
    else $error("Counter 0 did not wrap to zero");

  read_idle_a: assert property (
    !RD |=> RDATA == 32'h0000_0000)
    else $error("Read data not zero outside a read");

  exp_slot_a: assert property (
    (RD && ADDR == OFS_COUNT_BASE + 8'h20) |=> RDATA == $past(cnt_reg[NUM_LOCAL]))
    else $error("Slot 8 read returned wrong count");

  low_source_a: assert property (
    (src_a_reg[12:8] < 5'(FIRST_SRC) && !clr_w[1]) |=> $stable(cnt_reg[1]))
    else $error("Counter 1 moved with a low source");

  slow_path_a: assert property (
    !slow_tick |=> $stable(din_qual[FIRST_SRC-1]))
    else $error("Slow input moved between samples");

  idle_hold_a: assert property (
    (!inc_w[0] && !clr_w[0]) |=> $stable(cnt_reg[0]))
    else $error("Counter 0 moved without a counted edge");

  raw_step_a: assert property (
    !clr_w[0] |=> (cnt_reg[0] == $past(cnt_reg[0]) || cnt_reg[0] == $past(cnt_reg[0]) + 32'h0000_0001))
    else $error("Counter 0 stepped by more than one");

  clear_edge_a: assert property (
    (clr_w[0] && inc_w[0]) |=> cnt_reg[0] == 32'h0000_0000)
    else $error("Edge beat clear on counter 0");

  exp_clear_a: assert property (
    clr_w[NUM_LOCAL] |=> cnt_reg[NUM_LOCAL] == 32'h0000_0000)
    else $error("Expansion counter not cleared");

  low_hold_a: assert property (
    (!raw_w[0] && filt_reg[0] && dur_reg[0] < low_ms_reg) |=> filt_reg[0])
    else $error("Short low period dropped the filter");

  high_hold_a: assert property (
    (raw_w[0] && !filt_reg[0] && dur_reg[0] < high_ms_reg) |=> !filt_reg[0])
    else $error("Short high period raised the filter");

  both_edges_a: assert property (
    (flip_w[0] && edge_reg[1:0] == 2'b11 && valid_w[0] && !clr_w[0]) |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h0000_0001)
    else $error("Transition not counted with both edges set");

endmodule : fpc_counter_bank
`default_nettype wire

// ### fpc_pkg.sv
// Constants shared by the filtered pulse counter bank
`default_nettype none
package fpc_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NUM_LOCAL = 8;
  localparam int NUM_EXP = 8;
  localparam int NUM_CH = 16;
  localparam int NUM_DIN = 20;
  localparam int FIRST_SRC = 13;
  localparam int LAST_SRC = 20;
  localparam int FIRST_FAST = 15;
  localparam int CNT_W = 32;
  localparam int MS_W = 16;
  localparam int SEL_W = 5;
  localparam int SEL_STRIDE = 8;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_PERIOD_US = 1000;
  localparam int SLOW_PERIOD_US = 1;
  localparam int MS_CYCLES = CLK_HZ / 1_000_000 * MS_PERIOD_US;
  localparam int SLOW_CYCLES = CLK_HZ / 1_000_000 * SLOW_PERIOD_US;
  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_EDGE = 8'h00;
  localparam logic [7:0] OFS_LOW_MS = 8'h04;
  localparam logic [7:0] OFS_HIGH_MS = 8'h08;
  localparam logic [7:0] OFS_SRC_A = 8'h0c;
  localparam logic [7:0] OFS_SRC_B = 8'h10;
  localparam logic [7:0] OFS_CLR_A = 8'h14;
  localparam logic [7:0] OFS_CLR_B = 8'h18;
  localparam logic [7:0] OFS_CLEAR_CMD = 8'h1c;
  localparam logic [7:0] OFS_STATE = 8'h20;
  localparam logic [7:0] OFS_COUNT_BASE = 8'h40;
  localparam logic [7:0] OFS_COUNT_END = 8'h80;
  // ------------------------------------------------------------
  // Reset values and field masks
  // ------------------------------------------------------------
  localparam logic [31:0] RST_EDGE = 32'h0000_0000;
  localparam logic [MS_W-1:0] RST_MS = 16'h0000;
  localparam logic [31:0] RST_SEL = 32'h0000_0000;
  localparam logic [31:0] SEL_MASK = 32'h1f1f_1f1f;
endpackage : fpc_pkg
`default_nettype wire

// ### fpc_plant_model.sv
// Plant-side pulse source driving the counter bank inputs
`default_nettype none
module fpc_plant_model
  import fpc_pkg::*;
(
  input wire logic CLOCK,
  output logic [NUM_DIN-1:0] DIN,
  output logic [NUM_EXP-1:0] EXP_IN
);
  timeunit 1ns;
  timeprecision 1ns;
  // Channels 0..19 are plant inputs 1..20, 20..27 expansion inputs
  logic [NUM_DIN+NUM_EXP-1:0] pins_reg = '0;
  assign DIN = pins_reg[NUM_DIN-1:0];
  assign EXP_IN = pins_reg[NUM_DIN+NUM_EXP-1:NUM_DIN];

  task automatic set_pin(input int ch, input logic v);
    @(posedge CLOCK);
    pins_reg[ch] <= v;
  endtask : set_pin

  // Pulse train: hi cycles high, lo cycles low, n times
  task automatic pulse(input int ch, input int hi, input int lo, input int n);
    repeat (n) begin
      set_pin(ch, 1'b1);
      repeat (hi - 1) @(posedge CLOCK);
      set_pin(ch, 1'b0);
      repeat (lo - 1) @(posedge CLOCK);
    end
  endtask : pulse
endmodule : fpc_plant_model
`default_nettype wire
